// ==== verif/lcd_host_model.sv ====
// Host controller model for the LCD host port.
// Assumes the bench merges the data bus both ways.
`timescale 1ns/1ps
module lcd_host_model (
   input wire mclk_i,
   input wire m68_i,
   input wire [7:0] bus_i,
   output reg cs_n_o = 1'b1,
   output reg dc_o = 1'b0,
   output reg rw_wr_n_o = 1'b1,
   output reg e_rd_n_o = 1'b1,
   output reg [7:0] bus_o = 8'h00
);
   task cyc(input integer n);
      repeat (n) @(posedge mclk_i);
   endtask
   task wr(input s, input d, input [7:0] b);
      cyc(1);
      cs_n_o <= ~s;
      dc_o <= d;
      bus_o <= b;
      rw_wr_n_o <= 1'b0;
      e_rd_n_o <= 1'b1;
      cyc(6);
      rw_wr_n_o <= 1'b1;
      e_rd_n_o <= ~m68_i;
      cyc(4);
      cs_n_o <= 1'b1;
      bus_o <= ~b;
   endtask
   task rd(output [7:0] q);
      cyc(1);
      cs_n_o <= 1'b0;
      rw_wr_n_o <= 1'b1;
      e_rd_n_o <= m68_i;
      bus_o <= ~bus_o;
      cyc(8);
      q = bus_i;
      e_rd_n_o <= ~m68_i;
      cyc(2);
      cs_n_o <= 1'b1;
   endtask
   task ser(input d, input [7:0] b, input integer n);
      integer i;
      cyc(1);
      cs_n_o <= 1'b0;
      dc_o <= d;
      for (i = 7; i > 7 - n; i = i - 1) begin
         bus_o[7] <= b[i];
         cyc(12);
         bus_o[6] <= 1'b1;
         cyc(13);
         bus_o[6] <= 1'b0;
      end
      cyc(12);
      cs_n_o <= 1'b1;
      bus_o[7] <= ~b[0];
   endtask
endmodule

// ==== verif/lcd_host_port_bench.sv ====
// Bench for the LCD host port with host model and sink.
// Assumes the checker binds itself into the design.
`timescale 1ns/1ps
`include "lcd_host_regs.vh"
module lcd_host_port_bench;
   reg mclk = 1'b0;
   reg rstn = 1'b0;
   reg ready = 1'b1;
   reg ce = 1'b1;
   reg [7:0] rdata = 8'h5a;
   integer reads = 0;
   reg [1:0] mode = `MODE_I80;
   reg [8:0] q[$];
   reg [7:0] rv;
   reg [7:0] cmds [0:3] = '{`CMD_SLEEP_ON, `CMD_SLEEP_OFF, `CMD_STANDBY_ON, `CMD_STANDBY_OFF};
   reg [7:0] s3b [0:4] = '{`CMD_DATA_LEN, 8'h01, 8'h61, 8'h62, 8'h63};
   integer failures = 0;
   integer num_checks = 0;
   integer i;
   wire cs_n, dc, rw, e, oe, ram_we, cmd_we, osc, gnd, rreq;
   wire [7:0] hbus, dout, wdata;
   always #2.5 mclk = ~mclk;
   lcd_host_model i_lcd_host_model (.mclk_i(mclk), .m68_i(&mode), .bus_i(oe ? dout : hbus),
      .cs_n_o(cs_n), .dc_o(dc), .rw_wr_n_o(rw), .e_rd_n_o(e), .bus_o(hbus));
   lcd_host_port i_lcd_host_port (.mclk_i(mclk), .rstn_i(rstn), .ce_i(ce),
      .iface_sel_lo_i(mode[0]), .iface_sel_hi_i(mode[1]), .cs_n_i(cs_n), .dc_i(dc),
      .rw_wr_n_i(rw), .e_rd_n_i(e), .data_i(oe ? dout : hbus), .data_o(dout),
      .data_oe_o(oe), .read_data_i(rdata), .ram_we_o(ram_we), .cmd_we_o(cmd_we),
      .wdata_o(wdata), .sink_ready_i(ready), .read_req_o(rreq), .osc_run_o(osc),
      .column_gnd_o(gnd));
   always @(posedge mclk) if (ram_we || cmd_we) q.push_back({ram_we, wdata});
   always @(posedge mclk) if (rreq) reads <= reads + 1;
   task chk(input [8:0] g, input [8:0] x);
      num_checks = num_checks + 1;
      if (g !== x) begin
         failures = failures + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task ex(input r, input [7:0] b);
      integer n;
      n = 0;
      while (q.size() == 0 && n < 100) begin
         @(posedge mclk);
         n = n + 1;
      end
      chk(q.size() ? q.pop_front() : 9'h1ff, {r, b});
   endtask
   task print_verdict;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      failures = failures + 1;
      print_verdict;
   end
   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      i_lcd_host_model.cyc(4);
      chk({7'h0, osc, gnd}, 9'h0);
      i_lcd_host_model.wr(1, 0, `CMD_OSC_ON);
      ex(0, `CMD_OSC_ON);
      i_lcd_host_model.cyc(2);
      chk({8'h0, osc}, 9'h1);
      for (i = 0; i < 4; i = i + 1) begin
         i_lcd_host_model.wr(1, 0, cmds[i]);
         ex(0, cmds[i]);
         i_lcd_host_model.cyc(2);
         chk({8'h0, gnd}, {8'h0, ~i[0]});
      end
      i_lcd_host_model.wr(0, 1, 8'h77);
      i_lcd_host_model.cyc(20);
      chk(9'(q.size()), 9'h0);
      ce <= 1'b0;
      i_lcd_host_model.wr(1, 0, `CMD_OSC_OFF);
      ce <= 1'b1;
      i_lcd_host_model.cyc(10);
      chk(9'(q.size()), 9'h0);
      chk({8'h0, osc}, 9'h1);
      i_lcd_host_model.wr(1, 0, `CMD_OSC_OFF);
      ex(0, `CMD_OSC_OFF);
      i_lcd_host_model.cyc(2);
      chk({8'h0, osc}, 9'h0);
      i_lcd_host_model.wr(1, 0, `CMD_OSC_ON);
      ex(0, `CMD_OSC_ON);
      ready <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
         i_lcd_host_model.wr(1, 1, s3b[i + 2]);
      i_lcd_host_model.cyc(10);
      chk(9'(q.size()), 9'h0);
      ready <= 1'b1;
      ex(1, 8'h61);
      ex(1, 8'h62);
      i_lcd_host_model.cyc(20);
      chk(9'(q.size()), 9'h0);
      for (i = 0; i < 2; i = i + 1) begin
         mode <= i ? `MODE_I80 : `MODE_M68;
         rdata <= i ? 8'hc6 : 8'h5a;
         i_lcd_host_model.cyc(6);
         i_lcd_host_model.wr(1, 1, 8'h44);
         ex(1, 8'h44);
         i_lcd_host_model.rd(rv);
         i_lcd_host_model.rd(rv);
         chk({1'b0, rv}, {1'b0, rdata});
      end
      chk(9'(reads), 9'h004);
      mode <= `MODE_SPI4;
      i_lcd_host_model.cyc(6);
      i_lcd_host_model.ser(1, 8'hc3, 8);
      ex(1, 8'hc3);
      i_lcd_host_model.ser(0, 8'ha5, 3);
      i_lcd_host_model.ser(0, 8'h5e, 8);
      ex(0, 8'h5e);
      mode <= `MODE_SPI3;
      i_lcd_host_model.cyc(6);
      for (i = 0; i < 5; i = i + 1) begin
         i_lcd_host_model.ser(0, s3b[i], 8);
         ex(i == 2 || i == 3, s3b[i]);
      end
      chk({8'h0, osc}, 9'h1);
      rstn <= 1'b0;
      i_lcd_host_model.cyc(`RESET_MIN_NS / `CLK_PERIOD_NS);
      chk({7'h0, osc, gnd}, 9'h0);
      rstn <= 1'b1;
      i_lcd_host_model.cyc(4);
      chk({8'h0, osc}, 9'h0);
      print_verdict;
   end
endmodule

// ==== verif/lcd_host_port_sva.sv ====
// Checker on the LCD host port pins.
// Assumes bind into lcd_host_port.
`timescale 1ns/1ps
`include "lcd_host_regs.vh"
module lcd_host_port_sva (
   input wire mclk_i,
   input wire rstn_i,
   input wire iface_sel_lo_i,
   input wire cs_n_i,
   input wire sink_ready_i,
   input wire data_oe_o,
   input wire ram_we_o,
   input wire cmd_we_o,
   input wire [7:0] wdata_o,
   input wire osc_run_o,
   input wire column_gnd_o,
   input wire read_req_o
);
   // ------
   // Checks
   // ------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   a_one_target: assert property (!(ram_we_o && cmd_we_o))
      else $error("both writes");
   a_desel_quiet: assert property (
      (cs_n_i && sink_ready_i) [*8] |-> !(ram_we_o || cmd_we_o)) else $error("deselected write");
   a_serial_bus: assert property (!iface_sel_lo_i [*4] |-> !data_oe_o)
      else $error("serial drive");
   a_oe_select: assert property (cs_n_i [*4] |-> !data_oe_o)
      else $error("drive deselected");
   a_reset_clear: assert property (disable iff (1'b0)
      !rstn_i |-> !(ram_we_o || cmd_we_o || osc_run_o || column_gnd_o)) else $error("reset");
   a_osc_start: assert property ($rose(osc_run_o) |->
      wdata_o == `CMD_OSC_ON && (cmd_we_o || $past(cmd_we_o))) else $error("osc start");
   a_osc_stop: assert property ($fell(osc_run_o) |-> wdata_o == `CMD_OSC_OFF)
      else $error("osc stop");
   a_gnd_cause: assert property ($rose(column_gnd_o) |->
      wdata_o == `CMD_SLEEP_ON || wdata_o == `CMD_STANDBY_ON) else $error("gnd");
   a_read_pulse: assert property (read_req_o |-> data_oe_o ##1 !read_req_o)
      else $error("read pulse");
   c_ram: cover property (ram_we_o);
   c_cmd: cover property (cmd_we_o);
   c_read: cover property (data_oe_o);
endmodule
bind lcd_host_port lcd_host_port_sva i_chk (.mclk_i, .rstn_i, .iface_sel_lo_i, .cs_n_i,
   .sink_ready_i, .data_oe_o, .ram_we_o, .cmd_we_o, .wdata_o, .osc_run_o, .column_gnd_o,
   .read_req_o);

// ==== verilog/lcd_byte_buffer.v ====
// Two-entry buffer carrying {dc, byte} words toward RAM/decoder.
// Assumes one clock domain; read data held in a register.
`timescale 1ns/1ps
`include "lcd_host_regs.vh"
module lcd_byte_buffer #(
   parameter WIDTH = 9
) (
   input wire mclk_i,
   input wire rstn_i,
   input wire ce_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output reg out_valid_o,
   input wire out_ready_i,
   output reg [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_reg [0:`BUF_DEPTH-1];
   reg [`BUF_PTR_W-1:0] wr_ptr_reg;
   reg [`BUF_PTR_W-1:0] rd_ptr_reg;
   reg [`BUF_PTR_W:0] count_reg;
   wire push;
   wire pop;
   wire load;

   // Output register counts as one storage slot of the pair
   assign in_ready_o = ((count_reg + {1'b0, out_valid_o}) != `BUF_DEPTH);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign load = (count_reg != {(`BUF_PTR_W+1){1'b0}}) && (!out_valid_o || pop);

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr_reg <= 1'h0;
         rd_ptr_reg <= 1'h0;
         count_reg <= 2'h0;
         out_valid_o <= 1'b0;
         out_data_o <= {WIDTH{1'b0}};
         mem_reg[0] <= {WIDTH{1'b0}};
         mem_reg[1] <= {WIDTH{1'b0}};
      end else if (ce_i) begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (load) begin
            out_data_o <= mem_reg[rd_ptr_reg];
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
            out_valid_o <= 1'b1;
         end else if (pop) begin
            out_valid_o <= 1'b0;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, load};
      end
   end
endmodule

// ==== verilog/lcd_host_port.v ====
// Host port front end: serial or parallel bytes to RAM/decoder.
// Assumes host pins are asynchronous; RAM/decoder sit on mclk_i.
//
// Behaviour
// - Straps select SPI3, SPI4, 8080, 6800; reads parallel-only
// - Transfers only while chip select low
// - Data/command high to RAM, low decoder
// - 6800 read/write high reads, low writes
// - 8080 write starts on write strobe low
// - 6800 transfer starts on enable high
// - 8080 read starts on read strobe low
// - Serial data bit 7, clock bit 6
// - Reset low initialises all state
// - Oscillator stopped until start command
// - Sleep or standby grounds column drivers
// - SPI4 shifts MSB first, commits eighth clock
// - SPI3 data-length command sets data string
`timescale 1ns/1ps
`include "lcd_host_regs.vh"
module lcd_host_port (
   input wire mclk_i,
   input wire rstn_i,
   input wire ce_i,
   input wire iface_sel_lo_i,
   input wire iface_sel_hi_i,
   input wire cs_n_i,
   input wire dc_i,
   input wire rw_wr_n_i,
   input wire e_rd_n_i,
   input wire [7:0] data_i,
   output reg [7:0] data_o,
   output reg data_oe_o,
   input wire [7:0] read_data_i,
   output reg ram_we_o,
   output reg cmd_we_o,
   output reg [7:0] wdata_o,
   input wire sink_ready_i,
   output reg read_req_o,
   output reg osc_run_o,
   output reg column_gnd_o
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam SYNC_W = 8;
   wire [SYNC_W-1:0] raw_in;
   reg [SYNC_W-1:0] meta_reg;
   reg [SYNC_W-1:0] sync_reg;
   assign raw_in = {iface_sel_hi_i, iface_sel_lo_i, cs_n_i, dc_i, rw_wr_n_i, e_rd_n_i,
      data_i[`SER_DATA_BIT], data_i[`SER_CLK_BIT]};
   reg [7:0] dmeta_reg;
   reg [7:0] dsync_reg;

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_reg <= {SYNC_W{1'b1}};
         sync_reg <= {SYNC_W{1'b1}};
         dmeta_reg <= 8'h00;
         dsync_reg <= 8'h00;
      end else if (ce_i) begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
         dmeta_reg <= data_i;
         dsync_reg <= dmeta_reg;
      end
   end

   wire [1:0] mode;
   wire cs_n_s;
   wire dc_s;
   wire rw_s;
   wire erd_s;
   wire sda_s;
   wire sck_s;
   assign {mode, cs_n_s, dc_s, rw_s, erd_s, sda_s, sck_s} = sync_reg;

   // Serial mode decode, used in several places
   function is_serial;
      input [1:0] m;
      begin
         is_serial = (m == `MODE_SPI3) || (m == `MODE_SPI4);
      end
   endfunction

   // ------------------------------------------------------------
   // Strobe edge detection
   // ------------------------------------------------------------
   reg sck_d_reg;
   reg strobe_d_reg;
   wire sel = !cs_n_s;
   // 8080 write low, 6800 enable high
   wire wr_act = (mode == `MODE_I80) ? !rw_s : erd_s;
   // 6800 read when rw high; 8080 read strobe low
   wire rd_act = (mode == `MODE_I80) ? !erd_s : (erd_s && rw_s);
   wire wr_level = (mode == `MODE_I80) ? wr_act : (wr_act && !rw_s);
   wire wr_start = sel && wr_level && !strobe_d_reg && !is_serial(mode);
   wire sck_rise = sck_s && !sck_d_reg;

   // ------------------------------------------------------------
   // Serial shift, data-length tracking
   // ------------------------------------------------------------
   reg [`BIT_CNT_W-1:0] bit_cnt_reg;
   reg [6:0] shift_reg;
   reg [8:0] len_left_reg;
   reg len_arm_reg;
   wire [7:0] ser_byte = {shift_reg, sda_s};
   // sample on SCK rising, MSB first
   wire ser_done = sel && is_serial(mode) && sck_rise && (bit_cnt_reg == `BIT_LAST);
   wire ser_dc = (mode == `MODE_SPI4) ? dc_s : (len_left_reg != 9'h000);

   // Byte source to buffer
   wire in_valid = ser_done || wr_start;
   wire in_ready;
   wire [8:0] in_data = ser_done ? {ser_dc, ser_byte} : {dc_s, dsync_reg};
   wire [8:0] out_data;
   wire out_valid;
   wire out_ready = sink_ready_i;

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // Same level as the synchroniser reset: no false rise
         sck_d_reg <= 1'b1;
         strobe_d_reg <= 1'b0;
         bit_cnt_reg <= `BIT_ZERO;
         shift_reg <= 7'h00;
         len_left_reg <= 9'h000;
         len_arm_reg <= 1'b0;
      end else if (ce_i) begin
         sck_d_reg <= sck_s;
         strobe_d_reg <= wr_level;
         if (!sel) begin
            bit_cnt_reg <= `BIT_ZERO;
         end else if (is_serial(mode) && sck_rise) begin
            shift_reg <= ser_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
         end
         // length byte follows command, n+1 bytes
         if (ser_done && mode == `MODE_SPI3) begin
            if (len_arm_reg) begin
               len_left_reg <= {1'b0, ser_byte} + 9'h001;
               len_arm_reg <= 1'b0;
            end else if (len_left_reg != 9'h000) begin
               len_left_reg <= len_left_reg - 9'h001;
            end else begin
               len_arm_reg <= (ser_byte == `CMD_DATA_LEN);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Buffer toward RAM and decoder
   // ------------------------------------------------------------
   lcd_byte_buffer #(
      .WIDTH(9)
   ) u_buf (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .in_valid_i(in_valid),
      .in_ready_o(in_ready),
      .in_data_i(in_data),
      .out_valid_o(out_valid),
      .out_ready_i(out_ready),
      .out_data_o(out_data)
   );

   // ------------------------------------------------------------
   // Outputs, command effects, reads
   // ------------------------------------------------------------
   reg sleep_reg;
   reg standby_reg;
   wire take = out_valid && out_ready;
   wire cmd_take = take && !out_data[8];

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ram_we_o <= 1'b0;
         cmd_we_o <= 1'b0;
         wdata_o <= 8'h00;
         read_req_o <= 1'b0;
         data_o <= 8'h00;
         data_oe_o <= 1'b0;
         osc_run_o <= 1'b0;
         sleep_reg <= 1'b0;
         standby_reg <= 1'b0;
         column_gnd_o <= 1'b0;
      end else if (ce_i) begin
         ram_we_o <= take && out_data[8];
         cmd_we_o <= cmd_take;
         if (take) begin
            wdata_o <= out_data[7:0];
         end
         if (cmd_take && out_data[7:0] == `CMD_OSC_ON) begin
            osc_run_o <= 1'b1;
         end else if (cmd_take && out_data[7:0] == `CMD_OSC_OFF) begin
            osc_run_o <= 1'b0;
         end
         if (cmd_take && out_data[7:0] == `CMD_SLEEP_ON) begin
            sleep_reg <= 1'b1;
         end else if (cmd_take && out_data[7:0] == `CMD_SLEEP_OFF) begin
            sleep_reg <= 1'b0;
         end
         if (cmd_take && out_data[7:0] == `CMD_STANDBY_ON) begin
            standby_reg <= 1'b1;
         end else if (cmd_take && out_data[7:0] == `CMD_STANDBY_OFF) begin
            standby_reg <= 1'b0;
         end
         // ground columns in sleep or standby
         column_gnd_o <= sleep_reg || standby_reg;
         data_oe_o <= sel && rd_act && !is_serial(mode);
         read_req_o <= sel && rd_act && !is_serial(mode) && !data_oe_o;
         data_o <= read_data_i;
      end
   end
endmodule

// ==== verilog/lcd_host_regs.vh ====
// Constants for the LCD host port front end.
// Assumes inclusion by bare name from the design files.
`ifndef LCD_HOST_REGS_VH
`define LCD_HOST_REGS_VH
// Interface select codes {iface_sel_hi, iface_sel_lo}
`define MODE_SPI3 2'h0
`define MODE_SPI4 2'h2
`define MODE_I80 2'h1
`define MODE_M68 2'h3
// Serial pins on the data bus
`define SER_DATA_BIT 7
`define SER_CLK_BIT 6
// Byte layout
`define BYTE_W 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define BIT_ZERO 3'h0
// Commands seen by this front end
`define CMD_OSC_ON 8'hab
`define CMD_OSC_OFF 8'haa
`define CMD_SLEEP_ON 8'had
`define CMD_SLEEP_OFF 8'hac
`define CMD_STANDBY_ON 8'ha9
`define CMD_STANDBY_OFF 8'ha8
`define CMD_DATA_LEN 8'hb6
// Buffer
`define BUF_DEPTH 2
`define BUF_PTR_W 1
// Reset minimum pulse and clock
`define RESET_MIN_NS 10000
`define CLK_PERIOD_NS 5
`endif
